// file: hw/reset_source_and_watchdog.sv
// Overview of operation
// - Core stays in reset while the enabled supply monitor reports low supply.
// - Reset pin stays low for 100 ms after supply becomes good.
// - Small package always monitors; large package uses the monitor enable pin.
// - Leaving a power-on reset sets the power-on flag, bit 1.
// - Any other reset clears the power-on flag.
// - Every reset restarts program execution at address zero.
// - Writing 1 to the power-on flag forces a full power-on reset.
// - Supply failure while monitored re-enters reset; recovery uses the power-up delay.
// - Power-fail reset never clears or initialises internal data memory.
// - Watchdog disables only after writes 0xDE then 0xAD, in that order.
// - Second key must come within 4 system clocks, else ignored.
// - Writing 0xFF locks out disabling until the next system reset.
// - Writing the lockout value neither enables nor restarts the watchdog.
// - Timeout lasts 4 to the power (3 plus interval) system clock periods.
// - Reading watchdog control returns the programmed interval.
// - Every system reset loads interval 111b, the longest timeout.
// - Missing system clock for about 220 us generates a reset.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_and_watchdog_map.svh"

module reset_source_and_watchdog
  import reset_source_and_watchdog_pkg::*;
#(
  parameter bit SMALL_PACKAGE        = 1'b1,
  parameter int RESET_DELAY_CYCLES   = `RESET_DELAY_CYCLES,
  parameter int MISSING_CLOCK_CYCLES = `MISSING_CLOCK_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Supply monitor and system clock sense
  input  wire logic        supply_good,
  input  wire logic        monitor_enable_pin,
  input  wire logic        system_clock,
  // Open-drain reset pin
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_n,
  // Core control
  output logic             core_reset,
  output logic      [15:0] program_start_address
);

  localparam int DELAY_W   = $clog2(RESET_DELAY_CYCLES + 1);
  localparam int MISSING_W = $clog2(MISSING_CLOCK_CYCLES + 1);
  localparam int WDT_W     = 21;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reset_state_t         state;
  reset_state_t         next_state;
  logic [DELAY_W-1:0]   delay_count;
  logic [7:0]           hold_count;
  logic [MISSING_W-1:0] missing_count;
  logic                 system_clock_q;
  logic                 system_tick;
  logic                 monitor_active;
  logic                 supply_fail;
  logic                 missing_clock;
  logic                 external_reset;
  logic                 delay_done;
  logic                 hold_done;
  logic                 setup_phase;
  logic                 access_phase;
  logic                 hit_reset_source;
  logic                 hit_watchdog;
  logic                 reset_source_write;
  logic                 watchdog_write;
  logic                 force_power_on;
  logic [7:0]           write_byte;
  logic                 power_on_flag;
  logic                 pin_reset_flag;
  logic                 missing_clock_flag;
  logic                 watchdog_flag;
  logic                 watchdog_enabled;
  logic                 lockout;
  logic                 key_armed;
  logic [2:0]           key_age;
  interval_t            interval;
  logic [WDT_W-1:0]     watchdog_count;
  logic [WDT_W-1:0]     watchdog_limit;
  logic [4:0]           watchdog_exp;
  logic                 watchdog_expire;
  logic                 in_reset;

  // ----------------------------------------------------------------------
  // Input sensing
  // ----------------------------------------------------------------------
  // The system clock arrives as a sampled level; its rising edge is one tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clock_q <= 1'b0;
    end else begin
      system_clock_q <= system_clock;
    end
  end

  assign system_tick    = system_clock & ~system_clock_q;
  assign monitor_active = SMALL_PACKAGE | monitor_enable_pin;
  assign supply_fail    = monitor_active & ~supply_good;
  assign external_reset = reset_pin_oe_n & ~reset_pin_in;

  // Missing clock detector; counts pclk cycles since the last system tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      missing_count <= '0;
    end else if (system_tick) begin
      missing_count <= '0;
    end else if (!missing_clock) begin
      missing_count <= missing_count + 1'b1;
    end
  end

  assign missing_clock = (missing_count == MISSING_W'(MISSING_CLOCK_CYCLES));

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign setup_phase        = psel & ~penable;
  assign access_phase       = psel & penable;
  assign hit_reset_source   = (paddr == `REG_RESET_SOURCE);
  assign hit_watchdog       = (paddr == `REG_WATCHDOG_CONTROL);
  assign pready             = access_phase;
  assign pslverr            = access_phase & ~(hit_reset_source | hit_watchdog);
  assign write_byte         = pwdata[7:0];
  assign reset_source_write = access_phase & pwrite & hit_reset_source & pstrb[0];
  assign watchdog_write     = access_phase & pwrite & hit_watchdog & pstrb[0];
  assign force_power_on     = reset_source_write & write_byte[`POWER_ON_FLAG_BIT];

  // Read data is captured in the setup cycle so that it stands from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata <= '0;
      if (hit_reset_source) begin
        prdata[`PIN_RESET_FLAG_BIT]     <= pin_reset_flag;
        prdata[`POWER_ON_FLAG_BIT]      <= power_on_flag;
        prdata[`MISSING_CLOCK_FLAG_BIT] <= missing_clock_flag;
        prdata[`WATCHDOG_FLAG_BIT]      <= watchdog_flag;
      end else if (hit_watchdog) begin
        prdata[`INTERVAL_MSB:`INTERVAL_LSB] <= interval;
        prdata[`WATCHDOG_ACTIVE_BIT]        <= watchdog_enabled;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------------
  assign delay_done = (delay_count == DELAY_W'(RESET_DELAY_CYCLES - 1));
  assign hold_done  = (hold_count == (`SYS_RESET_HOLD - 8'h01));

  always_comb begin
    next_state = state;
    case (state)
      ST_SUPPLY_WAIT: begin
        if (!supply_fail) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (supply_fail) begin
          next_state = ST_SUPPLY_WAIT;
        end else if (delay_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (supply_fail) begin
          next_state = ST_SUPPLY_WAIT;
        end else if (force_power_on) begin
          next_state = ST_DELAY;
        end else if (missing_clock || watchdog_expire || external_reset) begin
          next_state = ST_SYS_RESET;
        end
      end
      ST_SYS_RESET: begin
        if (supply_fail) begin
          next_state = ST_SUPPLY_WAIT;
        end else if (hold_done && !missing_clock) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_SUPPLY_WAIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_SUPPLY_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // Delay and hold counters restart on every entry into their state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_count <= '0;
      hold_count  <= '0;
    end else begin
      if (next_state != ST_DELAY || state != ST_DELAY) begin
        delay_count <= '0;
      end else begin
        delay_count <= delay_count + 1'b1;
      end
      if (next_state != ST_SYS_RESET || state != ST_SYS_RESET || missing_clock) begin
        hold_count <= '0;
      end else if (!hold_done) begin
        hold_count <= hold_count + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reset cause flags
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_flag      <= 1'b0;
      pin_reset_flag     <= 1'b0;
      missing_clock_flag <= 1'b0;
      watchdog_flag      <= 1'b0;
    end else if (state == ST_DELAY && next_state == ST_RUN) begin
      power_on_flag      <= 1'b1;
      pin_reset_flag     <= 1'b0;
      missing_clock_flag <= 1'b0;
      watchdog_flag      <= 1'b0;
    end else if (state == ST_RUN && next_state == ST_SYS_RESET) begin
      power_on_flag      <= 1'b0;
      pin_reset_flag     <= external_reset;
      missing_clock_flag <= missing_clock;
      watchdog_flag      <= watchdog_expire;
    end
  end

  // ----------------------------------------------------------------------
  // Core and pin outputs
  // ----------------------------------------------------------------------
  // Only the core and the reset pin are held; nothing here touches data memory, so its
  // contents survive a power-fail reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset     <= 1'b1;
      reset_pin_oe_n <= 1'b0;
    end else begin
      core_reset     <= (next_state != ST_RUN);
      reset_pin_oe_n <= (next_state == ST_RUN);
    end
  end

  assign reset_pin_out = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_start_address <= `BOOT_ADDRESS;
    end else if (core_reset) begin
      program_start_address <= `BOOT_ADDRESS;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog timer
  // ----------------------------------------------------------------------
  assign in_reset        = core_reset;
  assign watchdog_exp    = 5'((`INTERVAL_BASE_EXP + {2'b00, interval}) << 1);
  assign watchdog_limit  = WDT_W'(1) << watchdog_exp;
  // At or past the limit, so a shortened interval never waits for a wrap
  assign watchdog_expire = watchdog_enabled & system_tick
                         & (watchdog_count >= (watchdog_limit - WDT_W'(1)));

  // Control state: everything returns to its defaults on any system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval         <= `INTERVAL_RESET;
      lockout          <= 1'b0;
      watchdog_enabled <= 1'b1;
      key_armed        <= 1'b0;
      key_age          <= '0;
    end else if (in_reset) begin
      interval         <= `INTERVAL_RESET;
      lockout          <= 1'b0;
      watchdog_enabled <= 1'b1;
      key_armed        <= 1'b0;
      key_age          <= '0;
    end else begin
      // The key window is counted in system clock ticks, not bus cycles
      if (key_armed && system_tick && key_age != `KEY_WINDOW_TICKS) begin
        key_age <= key_age + 3'h1;
      end
      if (watchdog_write) begin
        case (write_byte)
          `KEY_FIRST: begin
            key_armed <= 1'b1;
            key_age   <= '0;
          end
          `KEY_SECOND: begin
            key_armed <= 1'b0;
            if (key_armed && !lockout && key_age != `KEY_WINDOW_TICKS) begin
              watchdog_enabled <= 1'b0;
            end
          end
          `KEY_LOCKOUT: begin
            key_armed <= 1'b0;
            lockout   <= 1'b1;
          end
          `KEY_RESTART: begin
            key_armed        <= 1'b0;
            watchdog_enabled <= 1'b1;
          end
          default: begin
            key_armed <= 1'b0;
            // Values with the top bit set are keys, never interval writes
            if (!write_byte[`PROGRAM_BIT]) begin
              interval <= write_byte[`INTERVAL_MSB:`INTERVAL_LSB];
            end
          end
        endcase
      end
    end
  end

  // Timeout counter; the lockout write leaves it untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_count <= '0;
    end else if (in_reset) begin
      watchdog_count <= '0;
    end else if (watchdog_write && write_byte == `KEY_RESTART) begin
      watchdog_count <= '0;
    end else if (watchdog_enabled && system_tick) begin
      if (watchdog_expire) begin
        watchdog_count <= '0;
      end else begin
        watchdog_count <= watchdog_count + WDT_W'(1);
      end
    end
  end

endmodule

`default_nettype wire

// file: pkg/reset_source_and_watchdog_map.svh
`ifndef RESET_SOURCE_AND_WATCHDOG_MAP_SVH
`define RESET_SOURCE_AND_WATCHDOG_MAP_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define REG_RESET_SOURCE      8'h00
`define REG_WATCHDOG_CONTROL  8'h04

// ----------------------------------------------------------------------
// Reset source register fields
// ----------------------------------------------------------------------
`define PIN_RESET_FLAG_BIT      0
`define POWER_ON_FLAG_BIT       1
`define MISSING_CLOCK_FLAG_BIT  2
`define WATCHDOG_FLAG_BIT       3

// ----------------------------------------------------------------------
// Watchdog control values and fields
// ----------------------------------------------------------------------
`define KEY_FIRST             8'hde
`define KEY_SECOND            8'had
`define KEY_LOCKOUT           8'hff
`define KEY_RESTART           8'ha5
`define PROGRAM_BIT           7
`define WATCHDOG_ACTIVE_BIT   4
`define INTERVAL_MSB          2
`define INTERVAL_LSB          0
`define INTERVAL_RESET        3'h7
`define INTERVAL_BASE_EXP     5'h03
`define KEY_WINDOW_TICKS      3'h4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCLK_HZ               20000000
`define RESET_DELAY_MS        100
`define MISSING_CLOCK_US      220
`define RESET_DELAY_CYCLES    (`RESET_DELAY_MS * (`PCLK_HZ / 1000))
`define MISSING_CLOCK_CYCLES  (`MISSING_CLOCK_US * (`PCLK_HZ / 1000000))
`define SYS_RESET_HOLD        8'h10
`define BOOT_ADDRESS          16'h0000

`endif

// file: pkg/reset_source_and_watchdog_pkg.sv
`default_nettype none

package reset_source_and_watchdog_pkg;

  // ----------------------------------------------------------------------
  // Reset sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SUPPLY_WAIT = 2'b00,
    ST_DELAY       = 2'b01,
    ST_RUN         = 2'b10,
    ST_SYS_RESET   = 2'b11
  } reset_state_t;

  typedef logic [2:0] interval_t;

endpackage

`default_nettype wire

// file: testbench/reset_source_and_watchdog_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_and_watchdog_map.svh"

module reset_source_and_watchdog_asserts #(
  parameter bit SMALL_PACKAGE        = 1'b1,
  parameter int RESET_DELAY_CYCLES   = `RESET_DELAY_CYCLES,
  parameter int MISSING_CLOCK_CYCLES = `MISSING_CLOCK_CYCLES
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sensing and reset outputs
  input wire logic        supply_good,
  input wire logic        monitor_enable_pin,
  input wire logic        system_clock,
  input wire logic        reset_pin_oe_n,
  input wire logic        core_reset,
  input wire logic [15:0] program_start_address
);
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  int   good_cnt;
  int   idle_cnt;
  logic sys_q;
  logic mon_fail;

  assign mon_fail = (SMALL_PACKAGE || monitor_enable_pin) && !supply_good;

  // Saturating, so a long run never wraps the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      good_cnt <= 0;
    end else if (mon_fail) begin
      good_cnt <= 0;
    end else if (good_cnt < RESET_DELAY_CYCLES) begin
      good_cnt <= good_cnt + 1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_q    <= 1'b0;
      idle_cnt <= 0;
    end else begin
      sys_q <= system_clock;
      if (system_clock && !sys_q) begin
        idle_cnt <= 0;
      end else if (idle_cnt < 1000) begin
        idle_cnt <= idle_cnt + 1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_force_wr;
    psel && penable && pwrite && paddr == `REG_RESET_SOURCE
      && pwdata[`POWER_ON_FLAG_BIT] && pstrb[0] && !core_reset;
  endsequence

  property p_zero_wait;
    s_access |-> pready;
  endproperty
  property p_unmapped;
    psel && penable && !pwrite && paddr != `REG_RESET_SOURCE
      && paddr != `REG_WATCHDOG_CONTROL |-> pslverr && prdata == 32'h0;
  endproperty
  property p_upper_zero;
    psel && penable && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  property p_supply_core;
    mon_fail |-> ##[1:2] core_reset;
  endproperty
  property p_supply_pin;
    mon_fail |-> ##[1:2] !reset_pin_oe_n;
  endproperty
  property p_pin_core;
    !reset_pin_oe_n |-> core_reset;
  endproperty
  property p_delay;
    $fell(core_reset) |-> good_cnt >= RESET_DELAY_CYCLES;
  endproperty
  property p_boot;
    $fell(core_reset) |-> program_start_address == `BOOT_ADDRESS;
  endproperty
  property p_forced;
    s_force_wr |-> ##[1:2] core_reset;
  endproperty
  property p_missing;
    idle_cnt > MISSING_CLOCK_CYCLES + 4 |-> core_reset;
  endproperty

  a_zero_wait:   assert property (p_zero_wait) else $error("pready missing");
  a_unmapped:    assert property (p_unmapped) else $error("unmapped read not refused");
  a_upper_zero:  assert property (p_upper_zero) else $error("upper read bits set");
  a_supply_core: assert property (p_supply_core) else $error("low supply no reset");
  a_supply_pin:  assert property (p_supply_pin) else $error("low supply pin free");
  a_pin_core:    assert property (p_pin_core) else $error("pin low, core running");
  a_delay:       assert property (p_delay) else $error("reset released early");
  a_boot:        assert property (p_boot) else $error("start address wrong");
  a_forced:      assert property (p_forced) else $error("forced reset missing");
  a_missing:     assert property (p_missing) else $error("missing clock ignored");
endmodule

`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_and_watchdog_map.svh"

module tb
  import reset_source_and_watchdog_pkg::*;
;
  localparam int DLY = 50;
  localparam int MCK = 40;
  localparam logic [7:0] RS = `REG_RESET_SOURCE;
  localparam logic [7:0] WD = `REG_WATCHDOG_CONTROL;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        supply_good, monitor_enable_pin, system_clock, sys_run;
  logic        reset_pin_out, reset_pin_oe_n, core_reset, pin_pull;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] program_start_address;
  wire logic   reset_pin_in;
  int          bad_count, n_compared, n, t;

  // Open-drain wire with pull-up; pin_pull is an outside device pulling it low
  assign reset_pin_in = reset_pin_oe_n ? !pin_pull : reset_pin_out;

  reset_source_and_watchdog #(
    .SMALL_PACKAGE(1'b1), .RESET_DELAY_CYCLES(DLY), .MISSING_CLOCK_CYCLES(MCK)
  ) i_reset_source_and_watchdog (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .supply_good, .monitor_enable_pin, .system_clock,
    .reset_pin_in, .reset_pin_out, .reset_pin_oe_n, .core_reset, .program_start_address
  );

  // ----------------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // One system tick every two pclk cycles; sys_run low stops it
  always @(posedge pclk) if (sys_run) system_clock <= ~system_clock;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("mismatches %0d, compares %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      $display("unexpected at %0t: pready never came", $time);
      give_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sampled on the falling edge so registered outputs have settled
  task wait_core(input logic v, input int lim);
    n = 0;
    while (core_reset !== v && n < lim) begin
      @(negedge pclk);
      n++;
    end
    if (core_reset !== v) begin
      bad_count++;
      $display("unexpected at %0t: core reset wait ran out", $time);
      give_verdict;
    end
  endtask

  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pstrb = 4'hf; supply_good = 1'b1; monitor_enable_pin = 1'b0;
    system_clock = 1'b0; sys_run = 1'b1; bad_count = 0; n_compared = 0;
    pin_pull = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_core(1'b0, DLY + 20);
    chk(inr(n, DLY, DLY + 4), 32'h1);
    chk({16'h0, program_start_address}, 32'h0);
    apb(1'b0, RS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'b0, WD, 32'h0);
    chk(rd & 32'h17, 32'h17);
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Keyed disable, then lockout while stopped, then locked-out disable
    apb(1'b1, WD, `KEY_FIRST);
    apb(1'b1, WD, `KEY_SECOND);
    apb(1'b0, WD, 32'h0);
    chk(rd & 32'h10, 32'h0);
    apb(1'b1, WD, `KEY_LOCKOUT);
    apb(1'b0, WD, 32'h0);
    chk(rd & 32'h10, 32'h0);
    apb(1'b1, WD, `KEY_RESTART);
    apb(1'b1, WD, `KEY_FIRST);
    apb(1'b1, WD, `KEY_SECOND);
    apb(1'b0, WD, 32'h0);
    chk(rd & 32'h10, 32'h10);
    // Shortest interval: 4^3 ticks of two pclk each; lockout write must not restart
    apb(1'b1, WD, 32'h00);
    apb(1'b0, WD, 32'h0);
    chk(rd & 32'h17, 32'h10);
    apb(1'b1, WD, `KEY_RESTART);
    repeat (30) @(posedge pclk);
    apb(1'b1, WD, `KEY_LOCKOUT);
    wait_core(1'b1, 200);
    t = 33 + n;
    chk(inr(t, 124, 134), 32'h1);
    wait_core(1'b0, 60);
    apb(1'b0, RS, 32'h0);
    chk(rd & 32'ha, 32'h8);
    apb(1'b0, WD, 32'h0);
    chk(rd & 32'h17, 32'h17);
    // Second key too late: seven ticks after the first
    apb(1'b1, WD, `KEY_FIRST);
    repeat (12) @(posedge pclk);
    apb(1'b1, WD, `KEY_SECOND);
    apb(1'b0, WD, 32'h0);
    chk(rd & 32'h10, 32'h10);
    apb(1'b1, WD, `KEY_FIRST);
    apb(1'b1, WD, `KEY_SECOND);
    apb(1'b0, WD, 32'h0);
    chk(rd & 32'h10, 32'h0);
    // Stopped system clock
    sys_run <= 1'b0;
    wait_core(1'b1, MCK + 20);
    chk(inr(n, MCK, MCK + 8), 32'h1);
    repeat (10) @(posedge pclk);
    sys_run <= 1'b1;
    wait_core(1'b0, 60);
    apb(1'b0, RS, 32'h0);
    chk(rd & 32'h6, 32'h4);
    // Outside device pulls the reset pin low for a moment
    @(posedge pclk);
    pin_pull <= 1'b1;
    wait_core(1'b1, 4);
    @(posedge pclk);
    pin_pull <= 1'b0;
    wait_core(1'b0, 60);
    apb(1'b0, RS, 32'h0);
    chk(rd & 32'hf, 32'h1);
    // Supply dip; monitor pin low has no say on the small package
    @(posedge pclk);
    supply_good <= 1'b0;
    wait_core(1'b1, 4);
    chk(inr(n, 0, 3), 32'h1);
    repeat (10) @(posedge pclk);
    supply_good <= 1'b1;
    wait_core(1'b0, DLY + 20);
    chk(inr(n, DLY, DLY + 4), 32'h1);
    // Software forced power-on reset
    apb(1'b1, RS, 32'h2);
    wait_core(1'b1, 4);
    wait_core(1'b0, DLY + 20);
    chk(inr(n, DLY - 2, DLY + 4), 32'h1);
    apb(1'b0, RS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    give_verdict;
  end
endmodule

bind reset_source_and_watchdog reset_source_and_watchdog_asserts #(
  .SMALL_PACKAGE(SMALL_PACKAGE), .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES),
  .MISSING_CLOCK_CYCLES(MISSING_CLOCK_CYCLES)
) i_reset_source_and_watchdog_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .supply_good, .monitor_enable_pin, .system_clock,
  .reset_pin_oe_n, .core_reset, .program_start_address
);

`default_nettype wire
